// ===== shared/lbs_pkg.sv
package lbs_pkg;

    // ------------------------------------------------------------
    // sizes and result reset value
    // ------------------------------------------------------------
    localparam int LBS_BIT_DEPTH   = 8;
    localparam int LBS_BLK_DEPTH   = 8;
    localparam logic LBS_OPR_RESET = 1'b0;

    // ------------------------------------------------------------
    // step opcodes
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        LBS_NOP                        = 4'h0,
        LBS_BLOCK_LOAD_OP              = 4'h1,
        LBS_BLOCK_LOAD_INVERTED_OP     = 4'h2,
        LBS_SERIES_CONTACT_OP          = 4'h3,
        LBS_SERIES_INVERTED_CONTACT_OP = 4'h4,
        LBS_PARALLEL_CONTACT_OP        = 4'h5,
        LBS_PARALLEL_INVERTED_OP       = 4'h6,
        LBS_PARALLEL_MERGE_OP          = 4'h7,
        LBS_SERIES_MERGE_OP            = 4'h8,
        LBS_BIT_SAVE_OP                = 4'h9,
        LBS_BIT_PEEK_OP                = 4'hA,
        LBS_BIT_RESTORE_OP             = 4'hB
    } lbs_op_t;

    typedef struct packed
    {
        lbs_op_t op;
        logic    operand;
    } lbs_step_t;

    typedef struct packed
    {
        logic overflow;
        logic underflow;
    } lbs_err_t;

endpackage

// ===== src/lbs_lifo.sv
`timescale 1ns/100ps
module lbs_lifo
#(
    parameter int DEPTH = 8
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control
    input  wire logic push,
    input  wire logic pop,
    input  wire logic din,
    // state
    output logic      top,
    output logic      empty,
    output logic      full
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [DEPTH-1:0] ent_q;
    logic [DEPTH-1:0] ent_d;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;

    assign top   = ent_q[0];
    assign empty = (cnt_q == '0);
    assign full  = (cnt_q == CW'(DEPTH));

    // ------------------------------------------------------------
    // shift register stack, entry 0 is the first
    // ------------------------------------------------------------
    always_comb
    begin
        ent_d = ent_q;
        cnt_d = cnt_q;
        if (push && !full)
        begin
            ent_d = {ent_q[DEPTH-2:0], din};
            cnt_d = cnt_q + 1'b1;
        end
        else if (pop && !empty)
        begin
            ent_d = {1'b0, ent_q[DEPTH-1:1]};
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ent_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            ent_q <= ent_d;
            cnt_q <= cnt_d;
        end
    end
endmodule

// ===== src/lbs_unit.sv
`timescale 1ns/100ps
// Operation
// - parallel merge joins loaded blocks in parallel
// - parallel merge ORs last saved block in
// - interleaved or trailing merges give same result
// - bit save copies result into first entry
// - further saves shift entries deeper first
// - bit stack holds eight entries
// - bit peek reads first entry, stack unchanged
// - bit restore shifts entries up one
// - bit restore puts first entry in result
// - two AND blocks ORed drive output
// - saved branch point feeds each branch
// - series contact ANDs operand into result
// - series merge ANDs last saved block in
module lbs_unit
#(
    parameter int BIT_DEPTH = lbs_pkg::LBS_BIT_DEPTH,
    parameter int BLK_DEPTH = lbs_pkg::LBS_BLK_DEPTH
)
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // step from sequencer
    input  wire logic              step_valid,
    input  wire lbs_pkg::lbs_step_t step,
    // result
    output logic                   result,
    output lbs_pkg::lbs_err_t      err,
    output logic                   blk_in_progress
);
    import lbs_pkg::*;

    logic     opr_q;
    logic     opr_d;
    logic     act_q;
    logic     act_d;
    lbs_err_t err_q;
    lbs_err_t err_d;
    logic     step_over;
    logic     step_under;

    logic     blk_push;
    logic     blk_pop;
    logic     blk_top;
    logic     blk_empty;
    logic     blk_full;
    logic     bit_push;
    logic     bit_pop;
    logic     bit_top;
    logic     bit_empty;
    logic     bit_full;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign result          = opr_q;
    assign err             = err_q;
    assign blk_in_progress = act_q;

    // ------------------------------------------------------------
    // block result stack and bit stack
    // ------------------------------------------------------------
    // the first load of a program has no earlier block to save
    lbs_lifo #(.DEPTH(BLK_DEPTH)) u_blk
    (
        .clk   (clk),
        .rst   (rst),
        .push  (blk_push),
        .pop   (blk_pop),
        .din   (opr_q),
        .top   (blk_top),
        .empty (blk_empty),
        .full  (blk_full)
    );

    // saves beyond the last entry are refused, never dropped at the bottom
    lbs_lifo #(.DEPTH(BIT_DEPTH)) u_bit
    (
        .clk   (clk),
        .rst   (rst),
        .push  (bit_push),
        .pop   (bit_pop),
        .din   (opr_q),
        .top   (bit_top),
        .empty (bit_empty),
        .full  (bit_full)
    );

    // ------------------------------------------------------------
    // contact decoding
    // ------------------------------------------------------------
    // normally-closed forms see the inverse of the operand
    function automatic logic contact_level(input lbs_op_t op, input logic operand);
        logic closed;
        closed = (op == LBS_BLOCK_LOAD_INVERTED_OP)
              || (op == LBS_SERIES_INVERTED_CONTACT_OP)
              || (op == LBS_PARALLEL_INVERTED_OP);
        return operand ^ closed;
    endfunction

    // ------------------------------------------------------------
    // step execution
    // ------------------------------------------------------------
    always_comb
    begin
        opr_d      = opr_q;
        act_d      = act_q;
        step_over  = 1'b0;
        step_under = 1'b0;
        blk_push   = 1'b0;
        blk_pop    = 1'b0;
        bit_push   = 1'b0;
        bit_pop    = 1'b0;
        if (step_valid)
        begin
            unique case (step.op)
                LBS_BLOCK_LOAD_OP, LBS_BLOCK_LOAD_INVERTED_OP:
                begin
                    // a full block stack must not lose its oldest block
                    if (act_q && blk_full)
                        step_over = 1'b1;
                    else
                    begin
                        blk_push = act_q;
                        opr_d    = contact_level(step.op, step.operand);
                        act_d    = 1'b1;
                    end
                end
                LBS_SERIES_CONTACT_OP:
                    opr_d = opr_q & contact_level(step.op, step.operand);
                LBS_SERIES_INVERTED_CONTACT_OP:
                    opr_d = opr_q & contact_level(step.op, step.operand);
                LBS_PARALLEL_CONTACT_OP:
                    opr_d = opr_q | contact_level(step.op, step.operand);
                LBS_PARALLEL_INVERTED_OP:
                    opr_d = opr_q | contact_level(step.op, step.operand);
                LBS_PARALLEL_MERGE_OP, LBS_SERIES_MERGE_OP:
                begin
                    // top is read and popped in the same step
                    if (blk_empty)
                        step_under = 1'b1;
                    else
                    begin
                        blk_pop = 1'b1;
                        if (step.op == LBS_PARALLEL_MERGE_OP)
                            opr_d = blk_top | opr_q;
                        else
                            opr_d = blk_top & opr_q;
                    end
                end
                LBS_BIT_SAVE_OP:
                begin
                    // result itself is left as it is
                    if (bit_full)
                        step_over = 1'b1;
                    else
                        bit_push = 1'b1;
                end
                LBS_BIT_PEEK_OP:
                begin
                    // depth and contents of the bit stack are left alone
                    if (bit_empty)
                        step_under = 1'b1;
                    else
                        opr_d = bit_top;
                end
                LBS_BIT_RESTORE_OP:
                begin
                    // old first entry reaches the result as the shift lands
                    if (bit_empty)
                        step_under = 1'b1;
                    else
                    begin
                        bit_pop = 1'b1;
                        opr_d   = bit_top;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            opr_q <= LBS_OPR_RESET;
            act_q <= 1'b0;
        end
        else
        begin
            opr_q <= opr_d;
            act_q <= act_d;
        end
    end

    // ------------------------------------------------------------
    // sticky error flags, cleared only by reset
    // ------------------------------------------------------------
    // a refused step sets its flag and changes nothing else
    always_comb
    begin
        err_d = err_q;
        if (step_over)
            err_d.overflow = 1'b1;
        if (step_under)
            err_d.underflow = 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            err_q <= '0;
        else
            err_q <= err_d;
    end
endmodule

// ===== dv/lbs_unit_asserts.sv
`timescale 1ns/100ps
module lbs_unit_asserts
(
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               step_valid,
    input wire lbs_pkg::lbs_step_t step,
    input wire logic               result,
    input wire lbs_pkg::lbs_err_t  err,
    input wire logic               blk_in_progress
);
    import lbs_pkg::*;
    lbs_op_t op;
    assign op = step.op;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_load_value: assert property (step_valid && op == LBS_BLOCK_LOAD_OP
        |=> result == $past(step.operand) || err.overflow) else $error("load value wrong");
    a_inv_load: assert property (step_valid && op == LBS_BLOCK_LOAD_INVERTED_OP
        |=> result == !$past(step.operand) || err.overflow) else $error("inverted load wrong");
    a_series_and: assert property (step_valid && op == LBS_SERIES_CONTACT_OP
        |=> result == ($past(result) & $past(step.operand))) else $error("series wrong");
    a_series_inv: assert property (step_valid && op == LBS_SERIES_INVERTED_CONTACT_OP
        |=> result == ($past(result) & !$past(step.operand))) else $error("inv series wrong");
    a_save_keeps: assert property (step_valid && op == LBS_BIT_SAVE_OP
        |=> $stable(result)) else $error("save changed result");
    a_par_merge: assert property (step_valid && op == LBS_PARALLEL_MERGE_OP && result
        |=> result) else $error("parallel merge lost one");
    a_ser_merge: assert property (step_valid && op == LBS_SERIES_MERGE_OP && !result
        |=> !result) else $error("series merge gained one");
    a_blk_flag: assert property (step_valid && op inside {LBS_BLOCK_LOAD_OP}
        |=> blk_in_progress) else $error("block flag low after load");
    a_under_cause: assert property ($rose(err.underflow)
        |-> $past(step_valid) && $past(op)
        inside {LBS_PARALLEL_MERGE_OP, LBS_SERIES_MERGE_OP, LBS_BIT_PEEK_OP, LBS_BIT_RESTORE_OP})
        else $error("underflow without cause");
    a_over_cause: assert property ($rose(err.overflow)
        |-> $past(step_valid) && $past(op)
        inside {LBS_BLOCK_LOAD_OP, LBS_BLOCK_LOAD_INVERTED_OP, LBS_BIT_SAVE_OP})
        else $error("overflow without cause");
endmodule

// ===== dv/lbs_seq.sv
`timescale 1ns/100ps
module lbs_seq
(
    input  wire logic          clk,
    output logic               step_valid,
    output lbs_pkg::lbs_step_t step
);
    import lbs_pkg::*;
    initial
    begin
        step_valid = 1'b0;
        step       = '0;
    end
    // one step per cycle, held across the taking edge
    task automatic issue(input lbs_op_t op, input logic b);
        @(posedge clk);
        #2 step_valid = 1'b1;
        step = '{op: op, operand: b};
    endtask
    // idle operand keeps changing
    task automatic idle();
        @(posedge clk);
        #2 step_valid = 1'b0;
        step = '{op: LBS_NOP, operand: ~step.operand};
    endtask
endmodule

// ===== dv/test_lbs_unit.sv
`timescale 1ns/100ps
module test_lbs_unit;
    import lbs_pkg::*;
    logic      clk = 1'b0;
    logic      rst = 1'b1;
    logic      step_valid;
    lbs_step_t step;
    logic      result;
    lbs_err_t  err;
    logic      blk_in_progress;
    int        num_errors = 0;
    int        compares = 0;
    always #12.5 clk = ~clk;
    lbs_seq i_seq (.clk(clk), .step_valid(step_valid), .step(step));
    lbs_unit i_dut (.clk(clk), .rst(rst), .step_valid(step_valid), .step(step),
        .result(result), .err(err), .blk_in_progress(blk_in_progress));
    // ----
    // helpers
    // ----
    task automatic check(input string name, input logic [1:0] exp, input logic [1:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic restart();
        @(posedge clk);
        #2 rst = 1'b1;
        @(posedge clk);
        #2 rst = 1'b0;
    endtask
    task automatic run(input lbs_op_t op, input logic b, input logic exp);
        i_seq.issue(op, b);
        i_seq.idle();
        check("result", {1'b0, exp}, {1'b0, result});
    endtask
    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_two_blocks();
        for (int k = 0; k < 32; k++)
        begin
            restart();
            i_seq.issue(LBS_BLOCK_LOAD_OP, k[0]);
            i_seq.issue(LBS_SERIES_CONTACT_OP, k[1]);
            i_seq.issue(LBS_BLOCK_LOAD_OP, k[2]);
            i_seq.issue(LBS_SERIES_CONTACT_OP, k[3]);
            if (k[4])
                run(LBS_SERIES_MERGE_OP, 1'b0, k[0] & k[1] & k[2] & k[3]);
            else
                run(LBS_PARALLEL_MERGE_OP, 1'b0, k[0] & k[1] | k[2] & k[3]);
        end
    endtask
    task automatic t_merge_order();
        logic exp_m;
        for (int k = 0; k < 128; k++)
        begin
            restart();
            for (int b = 0; b < 3; b++)
            begin
                i_seq.issue(LBS_BLOCK_LOAD_OP, k[2*b]);
                i_seq.issue(LBS_SERIES_CONTACT_OP, k[2*b+1]);
                if (k[6] && b > 0)
                    i_seq.issue(LBS_PARALLEL_MERGE_OP, 1'b0);
            end
            if (!k[6])
            begin
                i_seq.issue(LBS_PARALLEL_MERGE_OP, 1'b0);
                i_seq.issue(LBS_PARALLEL_MERGE_OP, 1'b0);
            end
            i_seq.idle();
            exp_m = (k[0] & k[1]) | (k[2] & k[3]) | (k[4] & k[5]);
            check("merged", {1'b0, exp_m}, {1'b0, result});
        end
    endtask
    task automatic t_branch();
        for (int k = 0; k < 16; k++)
        begin
            restart();
            i_seq.issue(LBS_BLOCK_LOAD_OP, k[0]);
            run(LBS_BIT_SAVE_OP, 1'b0, k[0]);
            run(LBS_SERIES_CONTACT_OP, k[1], k[0] & k[1]);
            run(LBS_BIT_PEEK_OP, 1'b0, k[0]);
            run(LBS_SERIES_CONTACT_OP, k[2], k[0] & k[2]);
            run(LBS_BIT_RESTORE_OP, 1'b0, k[0]);
            run(LBS_SERIES_INVERTED_CONTACT_OP, k[3], k[0] & ~k[3]);
            run(LBS_BIT_PEEK_OP, 1'b0, k[0] & ~k[3]);
            check("error", 2'b01, err);
        end
    endtask
    task automatic t_deep();
        restart();
        check("block", 2'b00, {1'b0, blk_in_progress});
        run(LBS_SERIES_MERGE_OP, 1'b0, 1'b0);
        check("error", 2'b01, err);
        restart();
        run(LBS_BLOCK_LOAD_INVERTED_OP, 1'b1, 1'b0);
        check("block", 2'b01, {1'b0, blk_in_progress});
        run(LBS_PARALLEL_INVERTED_OP, 1'b1, 1'b0);
        run(LBS_PARALLEL_INVERTED_OP, 1'b0, 1'b1);
        for (int d = 0; d <= LBS_BIT_DEPTH; d++)
        begin
            i_seq.issue(LBS_SERIES_CONTACT_OP, d[0] ^ d[1]);
            i_seq.issue(LBS_PARALLEL_CONTACT_OP, d[0] ^ d[1]);
            i_seq.issue(LBS_BIT_SAVE_OP, 1'b0);
        end
        i_seq.idle();
        check("error", 2'b10, err);
        for (int d = LBS_BIT_DEPTH - 1; d >= -1; d--)
            run(LBS_BIT_RESTORE_OP, 1'b0, (d < 0) ? 1'b0 : d[0] ^ d[1]);
        check("error", 2'b11, err);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        #2 rst = 1'b0;
        t_two_blocks();
        t_merge_order();
        t_branch();
        t_deep();
        conclude();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors++;
        conclude();
    end
endmodule
bind lbs_unit lbs_unit_asserts i_chk (.clk(clk), .rst(rst), .step_valid(step_valid),
    .step(step), .result(result), .err(err), .blk_in_progress(blk_in_progress));
